// *** design/lfs_pkg.sv ***
// Constants, types and register map of the lift fault supervisor.
//
// Function
// - Door interlock opening while the car runs raises the interlock fault.
// - Encoder travel against the commanded direction raises the wrong-direction fault.
// - Brake feedback missing within 0.5 s or 2 s after release raises brake fault.
// - Brake feedback active while release is not driven raises brake fault; in the stop state only if still active 0.5 s or 2 s after entry.
// - Both leveling sensors held active too long while running raises stuck fault.
// - Too few encoder pulses while running raises the encoder fault.
// - Star feedback missing 0.4 s after star drive raises star contactor fault.
// - Star feedback active while star drive is off raises star contactor fault, except in the stop state.
// - Both safety chain inputs invalid raises the safety chain fault.
// - Passing a floor with no leveling sensor active raises leveling-missing fault.
// - Top overtravel input going invalid raises the overtravel-up fault.
// - Bottom overtravel input going invalid raises the overtravel-down fault.
// - Floor count disagreeing with a terminal switch raises the floor count fault.
// - After a floor count fault, go down at inspection speed and recalibrate.
// - A terminal switch forces deceleration and reloads the floor position.
// - Every stop at a target ends with a low speed crawl; recalibration stops from inspection speed.
// - Leveling trim defaults to 50; lower stops earlier, higher stops later.
package lfs_pkg;
	// ************************************************************
	// Register map and reset values
	// ************************************************************
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_TARGET = 8'h04;
	localparam logic [7:0] A_TRIM = 8'h08;
	localparam logic [7:0] A_TOPFL = 8'h0c;
	localparam logic [7:0] A_STATUS = 8'h10;
	localparam logic [7:0] A_MASK = 8'h14;
	localparam logic [7:0] A_INFO = 8'h18;
	localparam int C_START = 0;
	localparam int C_LONG = 1;
	localparam logic [7:0] TRIM_RST = 8'h32;
	localparam int TOPFL_RST = 5;
	// ************************************************************
	// Fault bits and their display codes
	// ************************************************************
	localparam int NF = 11;
	localparam int F_ILK = 0;
	localparam int F_DIR = 1;
	localparam int F_BRK = 2;
	localparam int F_STK = 3;
	localparam int F_ENC = 4;
	localparam int F_STAR = 5;
	localparam int F_SAF = 6;
	localparam int F_MISS = 7;
	localparam int F_OTU = 8;
	localparam int F_OTD = 9;
	localparam int F_FLR = 10;
	localparam logic [NF-1:0][7:0] FCODE = {8'h0e, 8'h0d, 8'h0c, 8'h0b, 8'h0a, 8'h09,
		8'h07, 8'h06, 8'h05, 8'h04, 8'h02};
	// ************************************************************
	// Timing, at a 10 MHz clock
	// ************************************************************
	localparam int CLK_KHZ = 10000;
	localparam int BRAKE_SHORT_MS = 500;
	localparam int BRAKE_LONG_MS = 2000;
	localparam int STAR_MS = 400;
	localparam int ENC_TIMEOUT_MS = 500;
	localparam int BRAKE_SHORT_CYC = BRAKE_SHORT_MS * CLK_KHZ;
	localparam int BRAKE_LONG_CYC = BRAKE_LONG_MS * CLK_KHZ;
	localparam int STAR_CYC = STAR_MS * CLK_KHZ;
	localparam int ENC_TIMEOUT_CYC = ENC_TIMEOUT_MS * CLK_KHZ;
	localparam int LEV_STUCK_PULSES = 2000;
	localparam int FLOOR_GAP_PULSES = 8000;
	// ************************************************************
	// Speed commands and states
	// ************************************************************
	localparam logic [1:0] SPD_STOP = 2'h0;
	localparam logic [1:0] SPD_CRAWL = 2'h1;
	localparam logic [1:0] SPD_INSP = 2'h2;
	localparam logic [1:0] SPD_NORM = 2'h3;
	typedef enum logic [2:0] {S_IDLE, S_STAR, S_BRAKE, S_RUN, S_CRAWL, S_RECAL, S_STOP,
		S_FAULT} lfs_state_t;
endpackage : lfs_pkg

// *** design/lfs_supervisor.sv ***
// Lift fault supervisor: trip sequencer, fault checks and APB registers.
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/1ps
module lfs_supervisor import lfs_pkg::*; #(
	parameter int FLOOR_W = 6,
	parameter int unsigned BRAKE_SHORT = BRAKE_SHORT_CYC,
	parameter int unsigned BRAKE_LONG = BRAKE_LONG_CYC,
	parameter int unsigned STAR_TIMEOUT = STAR_CYC,
	parameter int unsigned ENC_TIMEOUT = ENC_TIMEOUT_CYC,
	parameter int unsigned LEV_STUCK = LEV_STUCK_PULSES,
	parameter int unsigned FLOOR_GAP = FLOOR_GAP_PULSES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic door_interlock_ok,
	input wire logic safety_chain_in_a,
	input wire logic safety_chain_in_b,
	input wire logic leveling_sensor_a,
	input wire logic leveling_sensor_b,
	input wire logic top_overtravel_input,
	input wire logic bottom_overtravel_input,
	input wire logic top_terminal_switch,
	input wire logic bottom_terminal_switch,
	input wire logic brake_feedback_a,
	input wire logic brake_feedback_b,
	input wire logic star_contactor_feedback,
	input wire logic enc_pulse,
	input wire logic enc_up,
	output logic brake_release_drive,
	output logic star_contactor_drive,
	output logic [1:0] speed_cmd,
	output logic travel_up,
	output logic irq
);
	// ************************************************************
	// Sized limits
	// ************************************************************
	localparam logic [24:0] LIM_BS = 25'(BRAKE_SHORT);
	localparam logic [24:0] LIM_BL = 25'(BRAKE_LONG);
	localparam logic [24:0] LIM_ST = 25'(STAR_TIMEOUT);
	localparam logic [24:0] LIM_EN = 25'(ENC_TIMEOUT);
	localparam logic [15:0] LIM_STK = 16'(LEV_STUCK);
	localparam logic [15:0] LIM_GAP = 16'(FLOOR_GAP);
	localparam logic [FLOOR_W-1:0] FL_ZERO = '0;
	localparam logic [FLOOR_W-1:0] FL_ONE = FLOOR_W'(1);

	lfs_state_t st;
	lfs_state_t next_st;
	logic brake_long;
	logic [FLOOR_W-1:0] target;
	logic [FLOOR_W-1:0] top_floor;
	logic [FLOOR_W-1:0] floor_pos;
	logic [FLOOR_W-1:0] next_floor;
	logic [7:0] trim;
	logic [NF-1:0] status;
	logic [NF-1:0] mask;
	logic [7:0] fault_code;
	logic [24:0] tmr;
	logic [24:0] etmr;
	logic [15:0] gap_cnt;
	logic [15:0] zone_cnt;
	logic [15:0] trim_cnt;
	logic zone_q;
	logic top_q;
	logic bot_q;

	// ************************************************************
	// APB decode
	// ************************************************************
	// One wait state: pready rises in the second access cycle, so read data
	// is captured a cycle early and stands while pready is high.
	wire acc = psel & penable & pready;
	wire wr = acc & pwrite;
	wire rd_early = psel & penable & ~pready & ~pwrite;
	wire hit = paddr inside {A_CTRL, A_TARGET, A_TRIM, A_TOPFL, A_STATUS, A_MASK, A_INFO};
	wire wr_ctrl = wr & (paddr == A_CTRL);
	wire start_req = wr_ctrl & pwdata[C_START];
	wire [NF-1:0] w1c = (wr & (paddr == A_STATUS)) ? pwdata[NF-1:0] : '0;
	logic [31:0] rdata;
	always_comb begin
		rdata = '0;
		case (paddr)
			A_CTRL: rdata[C_LONG] = brake_long;
			A_TARGET: rdata[FLOOR_W-1:0] = target;
			A_TRIM: rdata[7:0] = trim;
			A_TOPFL: rdata[FLOOR_W-1:0] = top_floor;
			A_STATUS: rdata[NF-1:0] = status;
			A_MASK: rdata[NF-1:0] = mask;
			A_INFO: rdata = {8'h00, 5'h00, st, fault_code, 2'h0, 6'(floor_pos)};
			default: rdata = '0;
		endcase
	end

	// ************************************************************
	// Condition decode
	// ************************************************************
	wire running = st inside {S_RUN, S_CRAWL, S_RECAL};
	wire zone = leveling_sensor_a & leveling_sensor_b;
	wire any_lev = leveling_sensor_a | leveling_sensor_b;
	wire zone_rise = zone & ~zone_q;
	wire top_rise = top_terminal_switch & ~top_q;
	wire bot_rise = bottom_terminal_switch & ~bot_q;
	wire [24:0] brk_lim = brake_long ? LIM_BL : LIM_BS;
	wire brk_fb = brake_feedback_a | brake_feedback_b;
	wire pre_stop = travel_up ? (floor_pos + FL_ONE == target) : (floor_pos == target + FL_ONE);
	wire at_stop = (floor_pos == target) & (trim_cnt >= 16'(trim));
	wire recal_done = (st == S_RECAL) & bottom_terminal_switch & zone;

	// Fault events. The stop state lets contactors drop out before the
	// unsolicited-feedback checks apply, or every normal stop would trip.
	logic [NF-1:0] ev;
	assign ev[F_ILK] = running & ~door_interlock_ok;
	assign ev[F_DIR] = running & enc_pulse & (enc_up != travel_up);
	assign ev[F_BRK] = ((st == S_BRAKE) & (tmr >= brk_lim))
		| ((st == S_STOP) & (tmr >= brk_lim) & brk_fb)
		| ((st != S_STOP) & ~brake_release_drive & brk_fb);
	assign ev[F_STK] = running & (zone_cnt >= LIM_STK);
	assign ev[F_ENC] = running & (etmr >= LIM_EN);
	assign ev[F_STAR] = ((st == S_STAR) & (tmr >= LIM_ST))
		| ((st != S_STOP) & ~star_contactor_drive & star_contactor_feedback);
	assign ev[F_SAF] = ~safety_chain_in_a & ~safety_chain_in_b;
	assign ev[F_MISS] = running & (gap_cnt >= LIM_GAP);
	assign ev[F_OTU] = ~top_overtravel_input;
	assign ev[F_OTD] = ~bottom_overtravel_input;
	assign ev[F_FLR] = running & (st != S_RECAL)
		& ((top_rise & (floor_pos != top_floor)) | (bot_rise & (floor_pos != FL_ZERO)));
	wire hard_ev = |ev[F_FLR-1:0];
	wire [NF-1:0] next_status = (status & ~w1c) | ev;

	// Lowest set event names the fault code shown while latched.
	logic [7:0] ev_code;
	always_comb begin
		ev_code = 8'h00;
		for (int i = NF - 1; i >= 0; i--) begin
			if (ev[i]) begin
				ev_code = FCODE[i];
			end
		end
	end

	// ************************************************************
	// Trip sequencer
	// ************************************************************
	always_comb begin
		next_st = st;
		case (st)
			S_IDLE: begin
				if (start_req && target != floor_pos && target <= top_floor && status == '0) begin
					next_st = S_STAR;
				end
			end
			S_STAR: begin
				if (star_contactor_feedback) begin
					next_st = S_BRAKE;
				end
			end
			S_BRAKE: begin
				if (brk_fb) begin
					next_st = S_RUN;
				end
			end
			S_RUN: begin
				if (pre_stop || top_rise || bot_rise) begin
					next_st = S_CRAWL;
				end
			end
			S_CRAWL: begin
				if (at_stop) begin
					next_st = S_STOP;
				end
			end
			S_RECAL: begin
				if (recal_done) begin
					next_st = S_STOP;
				end
			end
			S_STOP: begin
				if (!brk_fb && !star_contactor_feedback) begin
					next_st = S_IDLE;
				end
			end
			S_FAULT: begin
				if (status == '0) begin
					next_st = S_IDLE;
				end
			end
			default: next_st = S_IDLE;
		endcase
		if (hard_ev) begin
			next_st = S_FAULT;
		end else if (ev[F_FLR]) begin
			next_st = S_RECAL;
		end
	end

	// Floor tracking: leveling zone entries step the count, terminal
	// switches reload it, and the bottom floor reloads it after recalibration.
	always_comb begin
		next_floor = floor_pos;
		if (recal_done) begin
			next_floor = FL_ZERO;
		end else if (running && st != S_RECAL && top_rise) begin
			next_floor = top_floor;
		end else if (running && st != S_RECAL && bot_rise) begin
			next_floor = FL_ZERO;
		end else if (running && st != S_RECAL && zone_rise) begin
			next_floor = travel_up ? floor_pos + FL_ONE : floor_pos - FL_ONE;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= S_IDLE;
			floor_pos <= '0;
		end else begin
			st <= next_st;
			floor_pos <= next_floor;
		end
	end

	// Drives follow the next state so that every output leaves a flip-flop.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			star_contactor_drive <= 1'b0;
			brake_release_drive <= 1'b0;
			speed_cmd <= SPD_STOP;
			travel_up <= 1'b0;
		end else begin
			star_contactor_drive <= next_st inside {S_STAR, S_BRAKE, S_RUN, S_CRAWL, S_RECAL};
			brake_release_drive <= next_st inside {S_BRAKE, S_RUN, S_CRAWL, S_RECAL};
			speed_cmd <= (next_st == S_RUN) ? SPD_NORM : (next_st == S_CRAWL) ? SPD_CRAWL
				: (next_st == S_RECAL) ? SPD_INSP : SPD_STOP;
			if (st == S_IDLE && next_st == S_STAR) begin
				travel_up <= target > floor_pos;
			end else if (next_st == S_RECAL) begin
				travel_up <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Timers and pulse counters
	// ************************************************************
	// The state timer restarts on every change of state and saturates.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tmr <= '0;
			etmr <= '0;
		end else begin
			tmr <= (next_st != st) ? '0 : (&tmr ? tmr : tmr + 25'h0000001);
			etmr <= (!running || enc_pulse) ? '0 : (&etmr ? etmr : etmr + 25'h0000001);
		end
	end

	// Trim counts pulses past the target zone entry; a larger trim stops later.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_cnt <= '0;
			zone_cnt <= '0;
			trim_cnt <= '0;
		end else begin
			gap_cnt <= (!running || any_lev) ? '0 : gap_cnt + {15'h0000, enc_pulse & ~&gap_cnt};
			zone_cnt <= (!running || !zone) ? '0 : zone_cnt + {15'h0000, enc_pulse & ~&zone_cnt};
			trim_cnt <= (st != S_CRAWL || zone_rise) ? '0
				: trim_cnt + {15'h0000, enc_pulse & ~&trim_cnt};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			zone_q <= 1'b0;
			top_q <= 1'b0;
			bot_q <= 1'b0;
		end else begin
			zone_q <= zone;
			top_q <= top_terminal_switch;
			bot_q <= bottom_terminal_switch;
		end
	end

	// ************************************************************
	// Registers and interrupt
	// ************************************************************
	// Status bits are sticky; a new event wins over a write-one clear.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status <= '0;
			fault_code <= 8'h00;
			irq <= 1'b0;
		end else begin
			status <= next_status;
			if (st == S_IDLE) begin
				fault_code <= 8'h00;
			end else if (fault_code == 8'h00 && ev != '0) begin
				fault_code <= ev_code;
			end
			irq <= |(status & mask);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask <= '0;
			brake_long <= 1'b0;
			target <= '0;
			trim <= TRIM_RST;
			top_floor <= FLOOR_W'(TOPFL_RST);
		end else if (wr) begin
			case (paddr)
				A_CTRL: brake_long <= pwdata[C_LONG];
				A_TARGET: target <= pwdata[FLOOR_W-1:0];
				A_TRIM: trim <= pwdata[7:0];
				A_TOPFL: top_floor <= pwdata[FLOOR_W-1:0];
				A_MASK: mask <= pwdata[NF-1:0];
				default: mask <= mask;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~hit;
			prdata <= rd_early ? rdata : '0;
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_interlock_open: assert property (running && !door_interlock_ok |=>
		status[F_ILK] && st == S_FAULT && !brake_release_drive)
		else $error("interlock open while running not latched");
	a_wrong_direction: assert property (running && enc_pulse && enc_up != travel_up
		|=> status[F_DIR] ##1 fault_code != 8'h00) else $error("wrong direction missed");
	a_brake_timeout: assert property (st == S_BRAKE && tmr >= brk_lim |=>
		status[F_BRK] && speed_cmd == SPD_STOP) else $error("brake timeout missed");
	a_brake_unsolicited: assert property (!brake_release_drive && brk_fb && st != S_STOP
		|=> status[F_BRK]) else $error("brake feedback without release missed");
	a_level_stuck: assert property (running && zone_cnt >= LIM_STK |=> status[F_STK])
		else $error("leveling stuck missed");
	a_encoder_idle: assert property (running && etmr >= LIM_EN |=> status[F_ENC])
		else $error("encoder pulse shortage missed");
	a_star_timeout: assert property (st == S_STAR && tmr >= LIM_ST |=> status[F_STAR])
		else $error("star contactor timeout missed");
	a_star_unsolicited: assert property (!star_contactor_drive && star_contactor_feedback
		&& st != S_STOP |=> status[F_STAR]) else $error("star feedback without drive missed");
	a_safety_open: assert property (!safety_chain_in_a && !safety_chain_in_b |=>
		status[F_SAF] ##1 !star_contactor_drive) else $error("safety chain open missed");
	a_floor_gap: assert property (running && gap_cnt >= LIM_GAP |=> status[F_MISS])
		else $error("leveling missing missed");
	a_overtravel_up: assert property ($fell(top_overtravel_input) |=> status[F_OTU])
		else $error("overtravel up missed");
	a_overtravel_down: assert property ($fell(bottom_overtravel_input) |=> status[F_OTD])
		else $error("overtravel down missed");
	a_floor_mismatch: assert property (st == S_RUN && bot_rise && floor_pos != FL_ZERO
		&& !hard_ev |=> status[F_FLR] && st == S_RECAL) else $error("floor mismatch missed");
	a_recal_motion: assert property (st == S_RECAL && !hard_ev && !recal_done |=>
		speed_cmd == SPD_INSP && !travel_up) else $error("recalibration not inspection down");
	a_terminal_reload: assert property (st == S_RUN && top_rise && !hard_ev && !ev[F_FLR]
		|=> floor_pos == top_floor && speed_cmd == SPD_CRAWL) else $error("terminal reload failed");
	a_crawl_first: assert property (st == S_STOP && $past(st) != S_STOP |->
		$past(st) inside {S_CRAWL, S_RECAL}) else $error("stop without crawl");
	a_trim_stop: assert property ($past(st) == S_CRAWL && st == S_STOP &&
		!$past(hard_ev) |-> $past(trim_cnt) >= 16'($past(trim))) else $error("stopped before trim");
	a_fault_hold: assert property (st == S_FAULT && status != '0 |=> st == S_FAULT)
		else $error("fault released while latched");
	a_irq_level: assert property (irq == $past(|(status & mask)))
		else $error("interrupt does not follow masked status");

	c_trip_done: cover property (st == S_CRAWL ##1 st == S_STOP ##[1:20] st == S_IDLE);
	c_recal_done: cover property (st == S_RECAL ##[1:1000] st == S_STOP);
	c_fault_clear: cover property (st == S_FAULT ##[1:100] st == S_IDLE);
	c_irq_raised: cover property ($rose(irq));
endmodule : lfs_supervisor

// *** sim/lfs_hoistway_model.sv ***
// Behavioural hoistway: contactor and brake contacts, encoder and leveling plates.
`timescale 1ns/1ps
module lfs_hoistway_model import lfs_pkg::*; (
	input wire logic pclk,
	input wire logic [6:0] mode,
	input wire logic brake_release_drive,
	input wire logic star_contactor_drive,
	input wire logic [1:0] speed_cmd,
	input wire logic travel_up,
	output logic star_contactor_feedback,
	output logic brake_feedback_a,
	output logic brake_feedback_b,
	output logic leveling_sensor_a,
	output logic leveling_sensor_b,
	output logic enc_pulse,
	output logic enc_up,
	output logic bottom_terminal_switch
);
	// Mode bits: 0 star dead, 1 brake dead, 2 motor reversed, 3 encoder dead,
	// 4 plates missing, 5 plates stuck, 6 all contacts welded closed.
	int pos = 1002;
	logic [2:0] star_d = 3'h0;
	logic [2:0] brk_d = 3'h0;
	logic ph = 1'b0;
	logic zone;
	// ************************************************************
	// Contacts and plates
	// ************************************************************
	// Contacts lag their coils by three cycles, so the design never sees an instant answer.
	assign zone = (pos % 20) < 4;
	assign star_contactor_feedback = mode[6] | (star_d[2] & !mode[0]);
	assign brake_feedback_a = mode[6] | (brk_d[2] & !mode[1]);
	assign brake_feedback_b = brake_feedback_a;
	assign leveling_sensor_a = mode[5] | (zone & !mode[4]);
	assign leveling_sensor_b = leveling_sensor_a;
	// The bottom terminal closes just above the lowest plate, so a run down meets it first.
	assign bottom_terminal_switch = pos < 1010;
	// ************************************************************
	// Car motion
	// ************************************************************
	// One encoder count every second cycle while any speed is commanded.
	always @(posedge pclk) begin
		star_d <= {star_d[1:0], star_contactor_drive};
		brk_d <= {brk_d[1:0], brake_release_drive};
		if (speed_cmd != SPD_STOP && !mode[3]) begin
			ph <= !ph;
			enc_pulse <= !ph;
			enc_up <= travel_up ^ mode[2];
			if (!ph) begin
				pos <= (travel_up ^ mode[2]) ? pos + 1 : pos - 1;
			end
		end else begin
			enc_pulse <= 1'b0;
		end
	end
endmodule : lfs_hoistway_model

// *** sim/test_lfs_supervisor.sv ***
// Self-checking bench for the lift fault supervisor.
`timescale 1ns/1ps
module test_lfs_supervisor import lfs_pkg::*; ;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err, saw_crawl;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic door_interlock_ok, safety_chain_in_a, safety_chain_in_b, irq;
	logic top_overtravel_input, bottom_overtravel_input, top_terminal_switch;
	logic bottom_terminal_switch, brake_feedback_a, brake_feedback_b, star_contactor_feedback;
	logic leveling_sensor_a, leveling_sensor_b, enc_pulse, enc_up, travel_up;
	logic brake_release_drive, star_contactor_drive;
	logic [1:0] speed_cmd;
	logic [6:0] mode;
	int error_cnt = 0;
	int tests_run = 0;
	lfs_supervisor #(.BRAKE_SHORT(50), .BRAKE_LONG(200), .STAR_TIMEOUT(40), .ENC_TIMEOUT(100),
		.LEV_STUCK(8), .FLOOR_GAP(30)) u_lfs_supervisor (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .door_interlock_ok,
		.safety_chain_in_a, .safety_chain_in_b, .leveling_sensor_a, .leveling_sensor_b,
		.top_overtravel_input, .bottom_overtravel_input, .top_terminal_switch,
		.bottom_terminal_switch, .brake_feedback_a, .brake_feedback_b,
		.star_contactor_feedback, .enc_pulse, .enc_up, .brake_release_drive,
		.star_contactor_drive, .speed_cmd, .travel_up, .irq);
	lfs_hoistway_model u_lfs_hoistway_model (.pclk, .mode, .brake_release_drive,
		.star_contactor_drive, .speed_cmd, .travel_up, .star_contactor_feedback,
		.brake_feedback_a, .brake_feedback_b, .leveling_sensor_a, .leveling_sensor_b,
		.enc_pulse, .enc_up, .bottom_terminal_switch);
	// ************************************************************
	// Clock, crawl monitor and shared tasks
	// ************************************************************
	// Clock of 100 ns; the monitor remembers any crawl phase seen.
	always #50 pclk = ~pclk;
	always @(posedge pclk) begin
		if (speed_cmd === SPD_CRAWL) begin
			saw_crawl <= 1'b1;
		end
	end
	task automatic conclude();
		$display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : chk
	// One APB transfer; it opens a clock edge later so back-to-back calls never collide.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			error_cnt++;
			conclude();
		end
		q = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wait_state(input logic [2:0] s);
		logic [31:0] q;
		for (int i = 0; i < 300; i++) begin
			apb(1'b0, A_INFO, 32'h0, q);
			if (q[18:16] === s) return;
		end
		error_cnt++;
		conclude();
	endtask : wait_state
	// Starts a trip: up to floor 1 from the bottom, otherwise down to the bottom.
	task automatic go(input logic longb);
		logic [31:0] q;
		apb(1'b0, A_INFO, 32'h0, q);
		apb(1'b1, A_TARGET, {31'h0, q[5:0] == 6'h0}, q);
		apb(1'b1, A_CTRL, {30'h0, longb, 1'b1}, q);
	endtask : go
	task automatic fault(input int b, input logic [7:0] code);
		logic [31:0] q;
		for (int i = 0; i < 150 && q[b] !== 1'b1; i++) begin
			apb(1'b0, A_STATUS, 32'h0, q);
		end
		chk({31'h0, q[b]}, 32'h1);
		apb(1'b0, A_INFO, 32'h0, q);
		chk({24'h0, q[15:8]}, {24'h0, code});
		if (b != F_FLR) begin
			chk({29'h0, q[18:16]}, {29'h0, S_FAULT});
		end
	endtask : fault
	// Latched status must survive until written off, and irq must follow it.
	task automatic clr();
		logic [31:0] q;
		apb(1'b0, A_STATUS, 32'h0, q);
		chk({31'h0, |q[10:0]}, 32'h1);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, A_STATUS, 32'h7ff, q);
		wait_state(3'h0);
		chk({31'h0, irq}, 32'h0);
	endtask : clr
	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_reset();
		logic [31:0] q;
		apb(1'b0, A_TRIM, 32'h0, q);
		chk(q, 32'h32);
		apb(1'b0, A_TOPFL, 32'h0, q);
		chk(q, 32'h5);
		apb(1'b0, 8'h40, 32'h0, q);
		chk({31'h0, last_err}, 32'h1);
		apb(1'b1, A_MASK, 32'h7ff, q);
	endtask : t_reset
	task automatic t_trip();
		logic [31:0] q;
		apb(1'b1, A_TRIM, 32'h2, q);
		apb(1'b0, A_TRIM, 32'h0, q);
		chk(q, 32'h2);
		saw_crawl <= 1'b0;
		apb(1'b1, A_TARGET, 32'h2, q);
		apb(1'b1, A_CTRL, 32'h1, q);
		wait_state(3'h0);
		apb(1'b0, A_INFO, 32'h0, q);
		chk(q, 32'h2);
		chk({31'h0, saw_crawl}, 32'h1);
	endtask : t_trip
	task automatic t_floor();
		logic [31:0] q;
		apb(1'b1, A_TARGET, 32'h4, q);
		apb(1'b1, A_CTRL, 32'h1, q);
		wait_state(S_RUN);
		top_terminal_switch <= 1'b1;
		wait_state(S_RECAL);
		fault(F_FLR, 8'h0e);
		chk({29'h0, travel_up, speed_cmd}, {29'h0, 1'b0, SPD_INSP});
		top_terminal_switch <= 1'b0;
		clr();
		apb(1'b0, A_INFO, 32'h0, q);
		chk({26'h0, q[5:0]}, 32'h0);
	endtask : t_floor
	task automatic t_star();
		logic [31:0] q;
		apb(1'b1, A_MASK, 32'h0, q);
		mode <= 7'h01;
		go(1'b0);
		apb(1'b0, A_STATUS, 32'h0, q);
		chk(q, 32'h0);
		fault(F_STAR, 8'h09);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, A_MASK, 32'h7ff, q);
		mode <= 7'h00;
		clr();
	endtask : t_star
	task automatic t_brake();
		logic [31:0] q;
		mode <= 7'h02;
		go(1'b1);
		repeat (100) @(posedge pclk);
		apb(1'b0, A_STATUS, 32'h0, q);
		chk({31'h0, q[F_BRK]}, 32'h0);
		fault(F_BRK, 8'h05);
		mode <= 7'h00;
		clr();
	endtask : t_brake
	task automatic t_motion();
		logic [6:0] modes[4] = '{7'h04, 7'h08, 7'h10, 7'h20};
		int bits[4] = '{F_DIR, F_ENC, F_MISS, F_STK};
		logic [7:0] codes[4] = '{8'h04, 8'h07, 8'h0b, 8'h06};
		for (int i = 0; i < 4; i++) begin
			mode <= modes[i];
			go(1'b0);
			fault(bits[i], codes[i]);
			mode <= 7'h00;
			clr();
		end
	endtask : t_motion
	// A three-floor trip keeps the car in full-speed running long enough to be seen there.
	task automatic t_ilk();
		logic [31:0] q;
		apb(1'b1, A_TARGET, 32'h3, q);
		apb(1'b1, A_CTRL, 32'h1, q);
		wait_state(S_RUN);
		door_interlock_ok <= 1'b0;
		fault(F_ILK, 8'h02);
		door_interlock_ok <= 1'b1;
		clr();
	endtask : t_ilk
	task automatic t_unsol();
		logic [31:0] q;
		mode <= 7'h40;
		repeat (10) @(posedge pclk);
		apb(1'b0, A_STATUS, 32'h0, q);
		chk({31'h0, q[F_BRK]}, 32'h1);
		chk({31'h0, q[F_STAR]}, 32'h1);
		mode <= 7'h00;
		clr();
	endtask : t_unsol
	task automatic t_limits();
		int bits[3] = '{F_SAF, F_OTU, F_OTD};
		logic [7:0] codes[3] = '{8'h0a, 8'h0c, 8'h0d};
		for (int i = 0; i < 3; i++) begin
			safety_chain_in_a <= i != 0;
			safety_chain_in_b <= i != 0;
			top_overtravel_input <= i != 1;
			bottom_overtravel_input <= i != 2;
			fault(bits[i], codes[i]);
			safety_chain_in_a <= 1'b1;
			safety_chain_in_b <= 1'b1;
			top_overtravel_input <= 1'b1;
			bottom_overtravel_input <= 1'b1;
			clr();
		end
	endtask : t_limits
	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		door_interlock_ok = 1'b1;
		safety_chain_in_a = 1'b1;
		safety_chain_in_b = 1'b1;
		top_overtravel_input = 1'b1;
		bottom_overtravel_input = 1'b1;
		top_terminal_switch = 1'b0;
		mode = 7'h00;
		saw_crawl = 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_trip();
		t_floor();
		t_star();
		t_brake();
		t_motion();
		t_ilk();
		t_unsol();
		t_limits();
		conclude();
	end
endmodule : test_lfs_supervisor
